//--- verilog/ewg_write_guard.sv
// Notes on behaviour
// - Guard register holds lowest protected word address.
// - Guard read shifts out dummy zero, guard register, then guard flag.
// - Guard unlock authorizes guard commands; guard flag unchanged.
// - Guard clear loads all ones into guard register.
// - Guard clear sets guard flag to one.
// - Guard write needs no prior guard clear, only the unlock.
// - Guard write loads address; words at or above it become protected.
// - Guard write sets guard flag to zero, readable by guard read.
// - Guard freeze sets one-time lock, freezing guard register forever.
// - Lock set refuses every guard register modification.
// - Lock unreadable; locked rewrite shows no busy, unlocked shows busy.
// - While programming, output low with select high; input ignored.
// - After programming, output high until start bit or select low.
// - Memory words are delivered holding all ones.
// - Guard opcodes decoded with guard-enable pin high.
// - Frame: select rises, start bit one, two opcode bits, six address.
// - Word write below guard only; page write only if all words below.
// - Fill honoured only when guard flag shows cleared.
`timescale 1ns/100ps
module ewg_write_guard
  import ewg_pkg::*;
#(
  parameter int PROG_TIME_NS = 2000
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic sclk_i,
  input wire logic cs_i,
  input wire logic sdi_i,
  input wire logic guard_en_i,
  input wire logic wr_en_pin_i,
  output logic q_o,
  output logic q_oe_o,
  output logic busy_o,
  input wire logic [ADDR_W-1:0] mem_raddr_i,
  output logic [DATA_W-1:0] mem_rdata_o
);
  localparam int PROG_CYCLES_RAW = (PROG_TIME_NS * CLK_MHZ) / NS_PER_US;
  localparam int PROG_CYCLES = (PROG_CYCLES_RAW < 1) ? 1 : PROG_CYCLES_RAW;
  localparam int TMR_W = $clog2(PROG_CYCLES + 1);
  localparam logic [TMR_W-1:0] TMR_LAST = TMR_W'(PROG_CYCLES - 1);
  localparam logic [ADDR_W-1:0] FILL_LAST = ADDR_W'((2**ADDR_W) - 1);

  if (PROG_TIME_NS < 1)
  begin : g_bad_time
    $error("PROG_TIME_NS must be positive");
  end

  // Link side, on the serial clock
  logic link_rst_n;
  logic started_q;
  logic rd_act_q;
  logic [HDR_BITS-1:0] rd_sh_q;
  logic tgl_q;
  logic [NBITS_W-1:0] nbits_q;
  logic [HDR_BITS-1:0] hdr_q;
  logic [PAGE_BITS-1:0] dat_q;
  logic [1:0] pins_q;
  logic [HDR_BITS-1:0] hdr_next;

  // Nonvolatile guard state, no reset
  logic [ADDR_W-1:0] guard_q = GUARD_CLEARED;
  logic flag_q = FLAG_CLEARED;
  logic lock_q = 1'b0;

  // Framing state ends with select low
  assign link_rst_n = arst_n_i & cs_i;
  assign hdr_next = {hdr_q[HDR_BITS-2:0], sdi_i};

  always_ff @(posedge sclk_i or negedge link_rst_n)
  begin
    if (!link_rst_n)
      started_q <= 1'b0;
    else if (sdi_i)
      started_q <= 1'b1;
  end

  // Guard value and flag only change while busy, when frames are dropped
  always_ff @(posedge sclk_i or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      rd_act_q <= 1'b0;
      rd_sh_q <= '0;
    end
    else if (started_q && nbits_q == HDR_LEN - 1'b1 && hdr_next[HDR_BITS-1 -: OP_W] == OP_READ
             && guard_en_i && pins_q[1])
    begin
      rd_act_q <= 1'b1;
      rd_sh_q <= {DUMMY_BIT, guard_q, flag_q};
    end
    else if (rd_act_q)
      rd_sh_q <= {rd_sh_q[HDR_BITS-2:0], STATUS_READY};
  end

  // Captured frame survives select low so the core can decode it
  always_ff @(posedge sclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      tgl_q <= 1'b0;
      nbits_q <= '0;
      hdr_q <= '0;
      dat_q <= '0;
      pins_q <= '0;
    end
    else if (!started_q && sdi_i && cs_i)
    begin
      tgl_q <= ~tgl_q;
      nbits_q <= '0;
      pins_q <= {guard_en_i, wr_en_pin_i};
    end
    else if (started_q)
    begin
      pins_q <= pins_q & {guard_en_i, wr_en_pin_i};
      if (nbits_q < HDR_LEN)
        hdr_q <= hdr_next;
      else
        dat_q <= {dat_q[PAGE_BITS-2:0], sdi_i};
      if (nbits_q != MAX_LEN)
        nbits_q <= nbits_q + 1'b1;
    end
  end

  // Core side
  logic cs_s;
  logic cs_d_q;
  logic cs_fall;
  logic cs_rise;
  logic seen_tgl_q;
  logic busy_frame_q;
  logic new_frame;
  logic take;
  logic wr_en_q;
  logic auth_q;
  logic stat_en_q;
  ewg_state_t state_q;
  logic [TMR_W-1:0] tmr_q;
  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] left_q;
  logic fill_q;
  logic [PAGE_BITS-1:0] cmd_dat_q;
  logic mem_we;

  ewg_sync #(
    .INIT(1'b0)
  ) u_cs_sync (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .d_i(cs_i),
    .q_o(cs_s)
  );

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      cs_d_q <= 1'b0;
    else
      cs_d_q <= cs_s;
  end

  assign cs_fall = cs_d_q & ~cs_s;
  assign cs_rise = ~cs_d_q & cs_s;
  assign new_frame = cs_fall && (tgl_q != seen_tgl_q);
  // Frames seen while programming are dropped
  assign take = new_frame && state_q == EWG_IDLE && !busy_frame_q;

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      seen_tgl_q <= 1'b0;
      busy_frame_q <= 1'b0;
    end
    else
    begin
      if (new_frame)
        seen_tgl_q <= tgl_q;
      if (cs_rise && state_q != EWG_IDLE)
        busy_frame_q <= 1'b1;
      else if (cs_fall)
        busy_frame_q <= 1'b0;
    end
  end

  // Decode of the frame just closed
  logic [1:0] op;
  logic [ADDR_W-1:0] adr;
  logic [1:0] sub;
  logic pre;
  logic wp;
  logic has_word;
  logic [2:0] nwords;
  logic do_wen;
  logic do_wds;
  logic do_unlock;
  logic do_gwrite;
  logic do_gclear;
  logic do_gfreeze;
  logic do_write;
  logic do_page;
  logic do_fill;
  logic guard_cmd;
  logic guard_ok;
  logic page_ok;

  always_comb
  begin
    op = hdr_q[HDR_BITS-1 -: OP_W];
    adr = hdr_q[ADDR_W-1:0];
    sub = adr[ADDR_W-1 -: 2];
    pre = pins_q[1];
    wp = pins_q[0];
    has_word = nbits_q >= WORD_LEN;
    nwords = 3'((nbits_q - HDR_LEN) >> 4);
    if (nwords > 3'(PAGE_WORDS))
      nwords = 3'(PAGE_WORDS);
    page_ok = 1'b1;
    for (int i = 0; i < PAGE_WORDS; i++)
    begin
      if (3'(i) < nwords && {adr[ADDR_W-1:2], 2'(adr[1:0] + 2'(i))} >= guard_q)
        page_ok = 1'b0;
    end
  end

  always_comb
  begin
    do_wen = 1'b0;
    do_wds = 1'b0;
    do_unlock = 1'b0;
    do_gwrite = 1'b0;
    do_gclear = 1'b0;
    do_gfreeze = 1'b0;
    do_write = 1'b0;
    do_page = 1'b0;
    do_fill = 1'b0;
    guard_cmd = 1'b0;
    if (take && nbits_q >= HDR_LEN)
    begin
      if (pre)
      begin
        unique case (op)
          OP_MISC:
          begin
            do_unlock = sub == SUB_ENABLE && wp && wr_en_q;
            guard_cmd = adr == ADDR_ZERO;
            do_gfreeze = guard_cmd;
          end
          OP_WRITE:
          begin
            guard_cmd = 1'b1;
            do_gwrite = 1'b1;
          end
          OP_PAGE:
          begin
            guard_cmd = adr == ADDR_ONES;
            do_gclear = guard_cmd;
          end
          OP_READ:
            guard_cmd = 1'b0;
        endcase
      end
      else
      begin
        unique case (op)
          OP_MISC:
          begin
            do_wen = sub == SUB_ENABLE && wp;
            do_wds = sub == SUB_DISABLE;
            do_fill = sub == SUB_FILL && wp && wr_en_q && has_word
                      && flag_q == FLAG_CLEARED;
          end
          OP_WRITE:
            do_write = wp && wr_en_q && has_word && adr < guard_q;
          OP_PAGE:
            do_page = wp && wr_en_q && has_word && page_ok;
          OP_READ:
            do_write = 1'b0;
        endcase
      end
    end
  end

  // Only an authorized, unlocked frame with both pins high may touch guard state
  assign guard_ok = auth_q && wp && !lock_q;

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      wr_en_q <= 1'b0;
    else if (do_wen)
      wr_en_q <= 1'b1;
    else if (do_wds)
      wr_en_q <= 1'b0;
  end

  // Authorization lasts exactly one following frame
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      auth_q <= 1'b0;
    else if (take)
      auth_q <= do_unlock;
  end

  always_ff @(posedge clk_i)
  begin
    if (guard_cmd && guard_ok)
    begin
      if (do_gwrite)
      begin
        guard_q <= adr;
        flag_q <= FLAG_PROTECTED;
      end
      else if (do_gclear)
      begin
        guard_q <= GUARD_CLEARED;
        flag_q <= FLAG_CLEARED;
      end
      else if (do_gfreeze)
        lock_q <= 1'b1;
    end
  end

  // Programming sequencer; a locked guard rewrite never starts it
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state_q <= EWG_IDLE;
      tmr_q <= '0;
    end
    else
    begin
      unique case (state_q)
        EWG_IDLE:
        begin
          tmr_q <= '0;
          if (do_write || do_page || do_fill)
            state_q <= EWG_LOAD;
          else if (guard_cmd && guard_ok)
            state_q <= EWG_WAIT;
        end
        EWG_LOAD:
        begin
          if (left_q == '0)
            state_q <= EWG_WAIT;
        end
        EWG_WAIT:
        begin
          tmr_q <= tmr_q + 1'b1;
          if (tmr_q == TMR_LAST)
            state_q <= EWG_IDLE;
        end
        default:
          state_q <= EWG_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      addr_q <= '0;
      left_q <= '0;
      fill_q <= 1'b0;
      cmd_dat_q <= '0;
    end
    else if (state_q == EWG_IDLE && (do_write || do_page || do_fill))
    begin
      fill_q <= do_fill;
      addr_q <= do_fill ? ADDR_ZERO : adr;
      left_q <= do_fill ? FILL_LAST : (do_page ? ADDR_W'(nwords - 3'h1) : ADDR_ZERO);
      cmd_dat_q <= do_page ? dat_q << (DATA_W * (PAGE_WORDS - int'(nwords)))
                           : {dat_q[DATA_W-1:0], {(PAGE_BITS-DATA_W){1'b0}}};
    end
    else if (state_q == EWG_LOAD && left_q != '0)
    begin
      left_q <= left_q - 1'b1;
      // Page writes wrap inside the page
      if (fill_q)
        addr_q <= addr_q + 1'b1;
      else
      begin
        addr_q[1:0] <= addr_q[1:0] + 1'b1;
        cmd_dat_q <= cmd_dat_q << DATA_W;
      end
    end
  end

  assign mem_we = state_q == EWG_LOAD;

  ewg_mem #(
    .AW(ADDR_W),
    .DW(DATA_W),
    .INIT(WORD_DELIVERED)
  ) u_mem (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .we_i(mem_we),
    .waddr_i(addr_q),
    .wdata_i(cmd_dat_q[PAGE_BITS-1 -: DATA_W]),
    .raddr_i(mem_raddr_i),
    .rdata_o(mem_rdata_o)
  );

  // Status shown only after a real programming cycle
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      stat_en_q <= 1'b0;
    else if (state_q == EWG_IDLE && (do_write || do_page || do_fill || (guard_cmd && guard_ok)))
      stat_en_q <= 1'b1;
    else if (new_frame)
      stat_en_q <= 1'b0;
  end

  assign busy_o = state_q != EWG_IDLE;
  // Output mux across domains; each leg is a stable flop while selected
  assign q_o = busy_o ? STATUS_BUSY : (rd_act_q ? rd_sh_q[HDR_BITS-1] : STATUS_READY);
  assign q_oe_o = cs_i & (busy_o | rd_act_q | (~started_q & stat_en_q));
endmodule // ewg_write_guard

//--- verilog/ewg_pkg.sv
package ewg_pkg;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 16;
  localparam int OP_W = 2;
  localparam int HDR_BITS = OP_W + ADDR_W;
  localparam int PAGE_WORDS = 4;
  localparam int PAGE_BITS = PAGE_WORDS * DATA_W;
  localparam int NBITS_W = 7;
  localparam int CLK_MHZ = 100;
  localparam int NS_PER_US = 1000;

  localparam logic [NBITS_W-1:0] HDR_LEN = NBITS_W'(HDR_BITS);
  localparam logic [NBITS_W-1:0] WORD_LEN = NBITS_W'(HDR_BITS + DATA_W);
  localparam logic [NBITS_W-1:0] MAX_LEN = NBITS_W'(HDR_BITS + PAGE_BITS);

  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_PAGE = 2'h3;
  localparam logic [1:0] OP_MISC = 2'h0;
  localparam logic [1:0] SUB_FILL = 2'h1;
  localparam logic [1:0] SUB_ENABLE = 2'h3;
  localparam logic [1:0] SUB_DISABLE = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_ONES = 6'h3f;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 6'h00;

  localparam logic [DATA_W-1:0] WORD_DELIVERED = 16'hffff;
  localparam logic [ADDR_W-1:0] GUARD_CLEARED = 6'h3f;
  localparam logic FLAG_CLEARED = 1'b1;
  localparam logic FLAG_PROTECTED = 1'b0;
  localparam logic DUMMY_BIT = 1'b0;
  localparam logic STATUS_BUSY = 1'b0;
  localparam logic STATUS_READY = 1'b1;

  typedef enum logic [2:0] {
    EWG_IDLE = 3'h1,
    EWG_LOAD = 3'h2,
    EWG_WAIT = 3'h4
  } ewg_state_t;
endpackage

//--- verilog/ewg_sync.sv
`timescale 1ns/100ps
module ewg_sync
  import ewg_pkg::*;
#(
  parameter logic INIT = 1'b0
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic d_i,
  output logic q_o
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
    end
    else
    begin
      s1_q <= d_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Change accepted only once the last two stages agree
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      q_o <= INIT;
    else if (s2_q == s3_q)
      q_o <= s3_q;
  end
endmodule // ewg_sync

//--- verilog/ewg_mem.sv
`timescale 1ns/100ps
module ewg_mem
  import ewg_pkg::*;
#(
  parameter int AW = ADDR_W,
  parameter int DW = DATA_W,
  parameter logic [DATA_W-1:0] INIT = WORD_DELIVERED
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [DW-1:0] rdata_o
);
  if (DW > DATA_W || AW < 1)
  begin : g_bad_size
    $error("ewg_mem size not supported");
  end

  // Array models nonvolatile cells, so no reset; delivered content all ones
  logic [DW-1:0] mem_q [2**AW] = '{default: INIT[DW-1:0]};

  always_ff @(posedge clk_i)
  begin
    if (we_i)
      mem_q[waddr_i] <= wdata_i;
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      rdata_o <= '0;
    else
      rdata_o <= mem_q[raddr_i];
  end
endmodule // ewg_mem

//--- test/ewg_write_guard_monitor.sv
`timescale 1ns/100ps
module ewg_write_guard_monitor
  import ewg_pkg::*;
#(
  parameter int PROG_TIME_NS = 2000
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic sclk_i,
  input wire logic cs_i,
  input wire logic sdi_i,
  input wire logic guard_en_i,
  input wire logic wr_en_pin_i,
  input wire logic q_o,
  input wire logic q_oe_o,
  input wire logic busy_o,
  input wire logic [ADDR_W-1:0] mem_raddr_i,
  input wire logic [DATA_W-1:0] mem_rdata_o
);
  logic [3:0] cnt_q;
  logic [2:0] hdr_q;
  // Bit position from the start bit, saturating so long reads stay cheap
  always_ff @(posedge sclk_i or negedge cs_i)
  begin
    if (!cs_i)
    begin
      cnt_q <= 4'h0;
      hdr_q <= 3'h0;
    end
    else if ((cnt_q != 4'h0 || sdi_i) && cnt_q != 4'hf)
    begin
      cnt_q <= cnt_q + 4'h1;
      hdr_q <= (cnt_q < 4'h3) ? {hdr_q[1:0], sdi_i} : hdr_q;
    end
  end
  sequence s_rd;
    cnt_q == 4'h8 && hdr_q == 3'h6 && guard_en_i && !busy_o;
  endsequence
  property p_busy_q;
    @(posedge clk_i) disable iff (!arst_n_i) busy_o && cs_i |-> q_oe_o && q_o == STATUS_BUSY;
  endproperty
  a_busy_q: assert property (p_busy_q) else $error("busy status wrong");
  property p_rdy_q;
    @(posedge clk_i) disable iff (!arst_n_i)
      $fell(busy_o) && cs_i |-> ##[0:2] (q_oe_o && q_o == STATUS_READY);
  endproperty
  a_rdy_q: assert property (p_rdy_q) else $error("ready status missing");
  property p_cs_low;
    @(posedge clk_i) disable iff (!arst_n_i) !cs_i |-> !q_oe_o;
  endproperty
  a_cs_low: assert property (p_cs_low) else $error("output driven while deselected");
  property p_busy_end;
    @(posedge clk_i) disable iff (!arst_n_i) $rose(busy_o) |-> ##[1:1000] !busy_o;
  endproperty
  a_busy_end: assert property (p_busy_end) else $error("cycle never ends");
  property p_busy_min;
    @(posedge clk_i) disable iff (!arst_n_i) $rose(busy_o) |-> busy_o [*8];
  endproperty
  a_busy_min: assert property (p_busy_min) else $error("cycle too short");
  property p_start;
    @(posedge clk_i) disable iff (!arst_n_i) $rose(busy_o) |-> !$past(cs_i, 3);
  endproperty
  a_start: assert property (p_start) else $error("cycle began inside a frame");
  property p_dummy;
    @(posedge sclk_i) disable iff (!arst_n_i) s_rd |=> q_oe_o && q_o == DUMMY_BIT;
  endproperty
  a_dummy: assert property (p_dummy) else $error("leading bit not zero");
  property p_rd_oe;
    @(posedge sclk_i) disable iff (!arst_n_i) s_rd |=> q_oe_o [*7];
  endproperty
  a_rd_oe: assert property (p_rd_oe) else $error("guard read output dropped");
  c_busy: cover property (@(posedge clk_i) $rose(busy_o));
  c_rdy: cover property (@(posedge clk_i) $fell(busy_o) && cs_i);
  c_rd: cover property (@(posedge sclk_i) s_rd);
endmodule // ewg_write_guard_monitor
bind ewg_write_guard ewg_write_guard_monitor #(.PROG_TIME_NS(PROG_TIME_NS)) i_mon (
  .clk_i(clk_i), .arst_n_i(arst_n_i), .sclk_i(sclk_i), .cs_i(cs_i), .sdi_i(sdi_i),
  .guard_en_i(guard_en_i), .wr_en_pin_i(wr_en_pin_i), .q_o(q_o), .q_oe_o(q_oe_o),
  .busy_o(busy_o), .mem_raddr_i(mem_raddr_i), .mem_rdata_o(mem_rdata_o));

//--- test/ewg_host_model.sv
`timescale 1ns/100ps
module ewg_host_model (
  input wire logic q_i,
  input wire logic q_oe_i,
  output logic sclk_o,
  output logic cs_o,
  output logic sdi_o,
  output logic guard_en_o,
  output logic wr_en_o,
  output logic [7:0] rx_o,
  output logic stb_o
);
  logic last_q;
  int gap_ns = 0;
  // Released line reads back inverted, never a stale level
  always @(q_i or q_oe_i)
    if (q_oe_i)
      last_q = q_i;
  initial
  begin
    {sclk_o, cs_o, sdi_o, guard_en_o, wr_en_o, rx_o, stb_o} = '0;
  end
  // Serial clock stands low between frames
  task automatic frame(input logic [40:0] v, input int n, input logic g, input logic w);
    guard_en_o = g;
    wr_en_o = w;
    #6 cs_o = 1'b1;
    for (int i = n - 1; i >= 0; i--)
    begin
      sdi_o = v[i];
      #6 sclk_o = 1'b1;
      #6 sclk_o = 1'b0;
      rx_o = {rx_o[6:0], q_oe_i ? q_i : ~last_q};
      #(gap_ns);
    end
    cs_o = 1'b0;
    sdi_o = ~sdi_o;
    #6 guard_en_o = 1'b0;
    wr_en_o = 1'b0;
    if (n == 16)
      stb_o = ~stb_o;
  endtask
  task automatic sel(input logic v);
    #2 cs_o = v;
  endtask
endmodule // ewg_host_model

//--- test/tb.sv
`timescale 1ns/100ps
module tb;
  import ewg_pkg::*;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic sclk, cs, sdi, gen, wen, q, qoe, busy, stb;
  logic [ADDR_W-1:0] raddr = 6'h00;
  logic [ADDR_W-1:0] a0;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] d0;
  logic [7:0] rx;
  logic [7:0] exp_q[$];
  int errors = 0;
  int checks_done = 0;
  always #5 clk_i = ~clk_i;
  ewg_write_guard #(.PROG_TIME_NS(100)) i_ewg_write_guard (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .sclk_i(sclk), .cs_i(cs), .sdi_i(sdi), .guard_en_i(gen), .wr_en_pin_i(wen), .q_o(q),
    .q_oe_o(qoe), .busy_o(busy), .mem_raddr_i(raddr), .mem_rdata_o(rdata));
  ewg_host_model i_host (.q_i(q), .q_oe_i(qoe), .sclk_o(sclk), .cs_o(cs), .sdi_o(sdi),
    .guard_en_o(gen), .wr_en_o(wen), .rx_o(rx), .stb_o(stb));
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic cmp(input string what, input logic [15:0] e, input logic [15:0] s);
    checks_done++;
    if (s !== e)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", what, e, s);
    end
  endtask
  always @(stb)
    if (exp_q.size() > 0)
      cmp("guard read", {8'h0, exp_q.pop_front()}, {8'h0, rx});
  task automatic cmd(input logic [1:0] op, input logic [5:0] a, input logic g);
    i_host.frame(41'({1'b1, op, a}), 9, g, 1'b1);
    repeat (8) @(negedge clk_i);
  endtask
  task automatic word(input logic [1:0] op, input logic [5:0] a, input logic [15:0] d);
    i_host.frame(41'({1'b1, op, a, d}), 25, 1'b0, 1'b1);
    repeat (8) @(negedge clk_i);
  endtask
  task automatic gread(input logic [5:0] a, input logic f);
    exp_q.push_back({DUMMY_BIT, a, f});
    i_host.frame(41'({1'b1, OP_READ, 13'h0}), 16, 1'b1, 1'b0);
    repeat (8) @(negedge clk_i);
  endtask
  task automatic mchk(input logic [5:0] a, input logic [15:0] e);
    raddr = a;
    repeat (2) @(negedge clk_i);
    cmp("word", e, rdata);
  endtask
  // Select raised once busy is seen or 60 cycles pass, and held until after ready, so busy and ready are both checked
  task automatic settle(input logic run);
    int n;
    n = 0;
    while (busy !== 1'b1 && n < 60)
    begin
      @(negedge clk_i);
      n++;
    end
    cmp("busy", 16'(run), 16'(busy));
    i_host.sel(1'b1);
    repeat (2) @(negedge clk_i);
    cmp("busy q", run ? 16'h2 : 16'h0, {14'h0, qoe, q & qoe});
    n = 0;
    while (busy !== 1'b0 && n < 1000)
    begin
      @(negedge clk_i);
      n++;
    end
    if (n == 1000)
    begin
      errors++;
      wrap_up();
    end
    repeat (2) @(negedge clk_i);
    cmp("ready q", run ? 16'h3 : 16'h0, {14'h0, qoe, q & qoe});
    i_host.sel(1'b0);
    repeat (8) @(negedge clk_i);
  endtask
  initial
  begin
    #900000;
    errors++;
    wrap_up();
  end
  initial
  begin
    void'($urandom(32'h0f7d));
    repeat (8) @(negedge clk_i);
    arst_n_i = 1'b1;
    repeat (6) @(negedge clk_i);
    gread(GUARD_CLEARED, FLAG_CLEARED);
    mchk(6'h2a, WORD_DELIVERED);
    cmd(OP_WRITE, 6'h10, 1'b1);
    settle(1'b0);
    gread(GUARD_CLEARED, FLAG_CLEARED);
    $display("test 1 done");
    a0 = 6'($urandom_range(62, 8));
    d0 = 16'($urandom);
    i_host.gap_ns = 20;
    cmd(OP_MISC, {SUB_ENABLE, 4'h0}, 1'b0);
    cmd(OP_MISC, {SUB_ENABLE, 4'h5}, 1'b1);
    cmd(OP_WRITE, a0, 1'b1);
    settle(1'b1);
    i_host.gap_ns = 0;
    gread(a0, FLAG_PROTECTED);
    word(OP_WRITE, a0, d0);
    settle(1'b0);
    mchk(a0, WORD_DELIVERED);
    word(OP_WRITE, a0 - 6'h01, d0);
    settle(1'b1);
    mchk(a0 - 6'h01, d0);
    word(OP_MISC, {SUB_FILL, 4'h0}, ~d0);
    settle(1'b0);
    $display("test 2 done");
    cmd(OP_MISC, {SUB_ENABLE, 4'h0}, 1'b1);
    gread(a0, FLAG_PROTECTED);
    cmd(OP_WRITE, 6'h05, 1'b1);
    settle(1'b0);
    cmd(OP_MISC, {SUB_ENABLE, 4'h0}, 1'b1);
    cmd(OP_PAGE, ADDR_ONES, 1'b1);
    settle(1'b1);
    gread(GUARD_CLEARED, FLAG_CLEARED);
    word(OP_MISC, {SUB_FILL, 4'h0}, ~d0);
    settle(1'b1);
    mchk(6'h00, ~d0);
    // Two-word page from the top slot, so the second word wraps to the page base
    i_host.frame({1'b1, OP_PAGE, 6'h07, d0, d0 ^ 16'h00ff}, 41, 1'b0, 1'b1);
    repeat (8) @(negedge clk_i);
    settle(1'b1);
    mchk(6'h07, d0);
    mchk(6'h04, d0 ^ 16'h00ff);
    $display("test 3 done");
    cmd(OP_MISC, {SUB_ENABLE, 4'h0}, 1'b1);
    cmd(OP_WRITE, a0, 1'b1);
    settle(1'b1);
    cmd(OP_MISC, {SUB_ENABLE, 4'h0}, 1'b1);
    cmd(OP_MISC, ADDR_ZERO, 1'b1);
    settle(1'b1);
    cmd(OP_MISC, {SUB_ENABLE, 4'h0}, 1'b1);
    cmd(OP_WRITE, a0 - 6'h01, 1'b1);
    settle(1'b0);
    cmd(OP_MISC, {SUB_ENABLE, 4'h0}, 1'b1);
    cmd(OP_PAGE, ADDR_ONES, 1'b1);
    settle(1'b0);
    gread(a0, FLAG_PROTECTED);
    cmd(OP_MISC, {SUB_DISABLE, 4'h0}, 1'b0);
    word(OP_WRITE, 6'h01, d0);
    settle(1'b0);
    $display("test 4 done");
    arst_n_i = 1'b0;
    repeat (4) @(negedge clk_i);
    arst_n_i = 1'b1;
    repeat (6) @(negedge clk_i);
    gread(a0, FLAG_PROTECTED);
    mchk(6'h00, ~d0);
    $display("test 5 done");
    wrap_up();
  end
endmodule // tb
